// ==== inc/dic_defines.vh ====
// Constants of the digital input conditioning block: offsets, fields, resets, timing.
// Assumes a 250 MHz clock; all slow timing runs from a 0.1 ms tick.
`ifndef DIC_DEFINES_VH
`define DIC_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DIC_OFS_CTRL    8'h00
`define DIC_OFS_THRESH  8'h04
`define DIC_OFS_STATUS  8'h08
`define DIC_OFS_MASK    8'h0C
`define DIC_OFS_INPUT   8'h10

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define DIC_CTRL_INRUSH   0
`define DIC_CTRL_OPEN     1
`define DIC_CTRL_COUNT    2
`define DIC_CTRL_FILT_LO  4
`define DIC_CTRL_EXT_LO   6
`define DIC_CTRL_RST      8'h50
`define DIC_CTRL_WMASK    8'hF7
`define DIC_THRESH_RST    16'h0001
`define DIC_THRESH_MAX    16'hFDE8
`define DIC_THRESH_MUL    16'h03E8

// ----------------------------------------
// Status fields
// ----------------------------------------
`define DIC_ST_OVC      0
`define DIC_ST_OPEN_LO  8
`define DIC_ST_CNT_LO   16

// ----------------------------------------
// Timing
// ----------------------------------------
`define DIC_CLK_PS      4000
`define DIC_TICK_PS     100000000
`define DIC_TICK_CYC    (`DIC_TICK_PS / `DIC_CLK_PS)
`define DIC_TICK_PER_MS 10
`define DIC_INRUSH_MS   100
`define DIC_INRUSH_TK   (`DIC_INRUSH_MS * `DIC_TICK_PER_MS)
`define DIC_SAVE_S      3600
`define DIC_SAVE_TK     (`DIC_SAVE_S * 1000 * `DIC_TICK_PER_MS)
`define DIC_FILT0_TK    11'h001
`define DIC_FILT1_TK    11'h00A
`define DIC_FILT2_TK    11'h064
`define DIC_FILT3_TK    11'h0C8
`define DIC_EXT0_TK     11'h00A
`define DIC_EXT1_TK     11'h096
`define DIC_EXT2_TK     11'h3E8
`define DIC_EXT3_TK     11'h7D0

`endif

// ==== logic/dic_cnt_ram.v ====
// Eight-word counter memory with one write port and a registered read port.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/10ps
`default_nettype none

module dic_cnt_ram (
    // Clock
    input  wire        aclk,
    // Write port
    input  wire        we,
    input  wire [2:0]  waddr,
    input  wire [31:0] wdata,
    // Read port
    input  wire [2:0]  raddr,
    output reg  [31:0] rdata_ff
);

    reg [31:0] mem [0:7];

    always @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_ff <= mem[raddr];
    end

endmodule // dic_cnt_ram

`default_nettype wire

// ==== logic/dic_top.v ====
// Digital input conditioning for eight field channels, with an AXI4-Lite register slave.
// Assumes inputs synchronous to aclk and a nonvolatile store with asynchronous read.
`timescale 1ns/10ps
`default_nettype none
`include "dic_defines.vh"

module dic_top #(
    parameter        HAS_OPEN_SENSE = 1,
    parameter [31:0] TICK_CYC       = `DIC_TICK_CYC,
    parameter [31:0] SAVE_TK        = `DIC_SAVE_TK
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Field side
    input  wire [7:0]  field_in,
    input  wire [7:0]  wire_open_in,
    input  wire        overcurrent_in,
    input  wire        inrush_in,
    // Nonvolatile count store
    output reg         nv_wr_en_ff,
    output reg  [2:0]  nv_addr_ff,
    output reg  [31:0] nv_wdata_ff,
    input  wire [31:0] nv_rdata,
    // Conditioned inputs and interrupt
    output reg  [7:0]  cond_out_ff,
    output reg         irq_ff,
    // AXI4-Lite write
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output reg         awready_ff,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready_ff,
    output reg  [1:0]  bresp_ff,
    output reg         bvalid_ff,
    input  wire        bready,
    // AXI4-Lite read
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output reg         arready_ff,
    output reg  [31:0] rdata_ff,
    output reg  [1:0]  rresp_ff,
    output reg         rvalid_ff,
    input  wire        rready
);

    localparam [2:0] S_LOAD = 3'b001;
    localparam [2:0] S_RUN  = 3'b010;
    localparam [2:0] S_SAVE = 3'b100;
    localparam [31:0] INRUSH_TK = `DIC_INRUSH_TK;

    // ----------------------------------------
    // Decoding helpers
    // ----------------------------------------
    function [10:0] filt_tk;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    filt_tk = `DIC_FILT0_TK;
                2'h1:    filt_tk = `DIC_FILT1_TK;
                2'h2:    filt_tk = `DIC_FILT2_TK;
                default: filt_tk = `DIC_FILT3_TK;
            endcase
        end
    endfunction

    function [10:0] ext_tk;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    ext_tk = `DIC_EXT0_TK;
                2'h1:    ext_tk = `DIC_EXT1_TK;
                2'h2:    ext_tk = `DIC_EXT2_TK;
                default: ext_tk = `DIC_EXT3_TK;
            endcase
        end
    endfunction

    function [2:0] first_set;
        input [7:0] v;
        integer i;
        begin
            first_set = 3'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = i[2:0];
                end
            end
        end
    endfunction

    // ----------------------------------------
    // Registers and tick
    // ----------------------------------------
    reg  [7:0]  ctrl_ff;
    reg  [15:0] thresh_ff;
    reg  [31:0] status_ff;
    reg  [31:0] mask_ff;
    reg  [31:0] tick_cnt_ff;
    reg         tick_ff;
    reg  [9:0]  inrush_cnt_ff;
    reg  [31:0] hour_cnt_ff;
    reg         save_req_ff;
    reg  [7:0]  stable_ff;
    reg  [7:0]  pend_ff;
    reg  [2:0]  state_ff;
    reg  [2:0]  idx_ff;
    reg         phase_ff;
    reg  [2:0]  cur_ff;
    wire [7:0]  rise;
    wire [31:0] ram_rdata;
    wire [31:0] limit;
    wire [31:0] inc_val;
    reg         ram_we;
    reg  [2:0]  ram_waddr;
    reg  [31:0] ram_wdata;
    reg  [2:0]  ram_raddr;
    reg  [31:0] hw_set;
    wire        wr_fire;
    wire        rd_fire;
    reg  [31:0] bmask;

    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff     <= 1'b0;
        end else if (tick_cnt_ff >= TICK_CYC - 32'h0000_0001) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff     <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff     <= 1'b0;
        end
    end

    // ----------------------------------------
    // Per-channel filter and stretch
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_ch
            reg [10:0] filt_ff;
            reg [10:0] hold_ff;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    filt_ff        <= 11'h000;
                    hold_ff        <= 11'h000;
                    stable_ff[g]   <= 1'b0;
                    cond_out_ff[g] <= 1'b0;
                end else begin
                    if (field_in[g] == stable_ff[g]) begin
                        filt_ff <= 11'h000;
                    end else if (tick_ff) begin
                        // Change must persist for the whole filter time.
                        if (filt_ff + 11'h001 >= filt_tk(ctrl_ff[5:4])) begin
                            stable_ff[g] <= field_in[g];
                            filt_ff      <= 11'h000;
                        end else begin
                            filt_ff <= filt_ff + 11'h001;
                        end
                    end
                    if (stable_ff[g]) begin
                        hold_ff <= ext_tk(ctrl_ff[7:6]);
                    end else if (tick_ff && hold_ff != 11'h000) begin
                        hold_ff <= hold_ff - 11'h001;
                    end
                    cond_out_ff[g] <= stable_ff[g] | (hold_ff != 11'h000);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Overcurrent with inrush mask
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            inrush_cnt_ff <= 10'h000;
        end else if (inrush_in) begin
            inrush_cnt_ff <= INRUSH_TK[9:0];
        end else if (tick_ff && inrush_cnt_ff != 10'h000) begin
            inrush_cnt_ff <= inrush_cnt_ff - 10'h001;
        end
    end

    // ----------------------------------------
    // Count engine: restore, count, hourly save
    // ----------------------------------------
    assign rise    = ~cond_out_ff & {g_ch[7].hold_ff != 11'h000 | stable_ff[7],
                                     g_ch[6].hold_ff != 11'h000 | stable_ff[6],
                                     g_ch[5].hold_ff != 11'h000 | stable_ff[5],
                                     g_ch[4].hold_ff != 11'h000 | stable_ff[4],
                                     g_ch[3].hold_ff != 11'h000 | stable_ff[3],
                                     g_ch[2].hold_ff != 11'h000 | stable_ff[2],
                                     g_ch[1].hold_ff != 11'h000 | stable_ff[1],
                                     g_ch[0].hold_ff != 11'h000 | stable_ff[0]};
    assign limit   = {16'h0000, thresh_ff} * {16'h0000, `DIC_THRESH_MUL};
    assign inc_val = (ram_rdata == 32'hFFFF_FFFF) ? ram_rdata : ram_rdata + 32'h0000_0001;

    dic_cnt_ram u_ram (
        .aclk     (aclk),
        .we       (ram_we),
        .waddr    (ram_waddr),
        .wdata    (ram_wdata),
        .raddr    (ram_raddr),
        .rdata_ff (ram_rdata)
    );

    always @* begin
        ram_we    = 1'b0;
        ram_waddr = idx_ff;
        ram_wdata = nv_rdata;
        ram_raddr = idx_ff;
        hw_set    = 32'h0000_0000;
        if (state_ff == S_LOAD && phase_ff) begin
            ram_we = 1'b1;
        end
        if (state_ff == S_RUN) begin
            ram_raddr = first_set(pend_ff);
            if (phase_ff) begin
                ram_we    = 1'b1;
                ram_waddr = cur_ff;
                ram_wdata = inc_val;
                hw_set[`DIC_ST_CNT_LO + cur_ff] = (inc_val > limit);
            end
        end
        hw_set[`DIC_ST_OVC] = overcurrent_in &
            !(ctrl_ff[`DIC_CTRL_INRUSH] && inrush_cnt_ff != 10'h000);
        if (HAS_OPEN_SENSE != 0 && ctrl_ff[`DIC_CTRL_OPEN]) begin
            hw_set[`DIC_ST_OPEN_LO +: 8] = wire_open_in;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff    <= S_LOAD;
            idx_ff      <= 3'h0;
            phase_ff    <= 1'b0;
            cur_ff      <= 3'h0;
            pend_ff     <= 8'h00;
            hour_cnt_ff <= 32'h0000_0000;
            save_req_ff <= 1'b0;
            nv_wr_en_ff <= 1'b0;
            nv_addr_ff  <= 3'h0;
            nv_wdata_ff <= 32'h0000_0000;
        end else begin
            nv_wr_en_ff <= 1'b0;
            if (tick_ff) begin
                if (hour_cnt_ff >= SAVE_TK - 32'h0000_0001) begin
                    hour_cnt_ff <= 32'h0000_0000;
                    save_req_ff <= 1'b1;
                end else begin
                    hour_cnt_ff <= hour_cnt_ff + 32'h0000_0001;
                end
            end
            // Newly seen edges win over the service clear of the same cycle.
            pend_ff <= (pend_ff & ~((state_ff == S_RUN && !phase_ff && pend_ff != 8'h00)
                       ? (8'h01 << first_set(pend_ff)) : 8'h00))
                       | (ctrl_ff[`DIC_CTRL_COUNT] ? rise : 8'h00);
            case (state_ff)
                S_LOAD: begin
                    nv_addr_ff <= idx_ff;
                    phase_ff   <= ~phase_ff;
                    if (phase_ff) begin
                        idx_ff <= idx_ff + 3'h1;
                        if (idx_ff == 3'h7) begin
                            state_ff <= S_RUN;
                        end
                    end
                end
                S_RUN: begin
                    if (phase_ff) begin
                        phase_ff <= 1'b0;
                    end else if (pend_ff != 8'h00) begin
                        cur_ff   <= first_set(pend_ff);
                        phase_ff <= 1'b1;
                    end else if (save_req_ff) begin
                        save_req_ff <= 1'b0;
                        idx_ff      <= 3'h0;
                        state_ff    <= S_SAVE;
                    end
                end
                S_SAVE: begin
                    phase_ff <= ~phase_ff;
                    if (phase_ff) begin
                        nv_wr_en_ff <= 1'b1;
                        nv_addr_ff  <= idx_ff;
                        nv_wdata_ff <= ram_rdata;
                        idx_ff      <= idx_ff + 3'h1;
                        if (idx_ff == 3'h7) begin
                            state_ff <= S_RUN;
                        end
                    end
                end
                default: begin
                    state_ff <= S_RUN;
                    phase_ff <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    assign wr_fire = awready_ff & awvalid & wvalid;
    assign rd_fire = arready_ff & arvalid;

    always @* begin
        bmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= 2'b00;
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= 2'b00;
            rdata_ff   <= 32'h0000_0000;
            ctrl_ff    <= `DIC_CTRL_RST;
            thresh_ff  <= `DIC_THRESH_RST;
            status_ff  <= 32'h0000_0000;
            mask_ff    <= 32'h0000_0000;
            irq_ff     <= 1'b0;
        end else begin
            awready_ff <= !awready_ff && !bvalid_ff && awvalid && wvalid;
            wready_ff  <= !awready_ff && !bvalid_ff && awvalid && wvalid;
            if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= 2'b00;
                if (awaddr == `DIC_OFS_CTRL) begin
                    ctrl_ff <= (ctrl_ff & ~(bmask[7:0] & `DIC_CTRL_WMASK))
                             | (wdata[7:0] & bmask[7:0] & `DIC_CTRL_WMASK);
                end else if (awaddr == `DIC_OFS_THRESH) begin
                    // Out-of-range thresholds are dropped; the old value stays.
                    if (wstrb[1:0] == 2'b11 && wdata[15:0] != 16'h0000
                        && wdata[15:0] <= `DIC_THRESH_MAX) begin
                        thresh_ff <= wdata[15:0];
                    end
                end else if (awaddr == `DIC_OFS_MASK) begin
                    mask_ff <= (mask_ff & ~bmask) | (wdata & bmask);
                end else if (awaddr != `DIC_OFS_STATUS && awaddr != `DIC_OFS_INPUT) begin
                    bresp_ff <= 2'b10;
                end
            end
            // Hardware set wins over a write-one clear in the same cycle.
            status_ff <= (status_ff & ~((wr_fire && awaddr == `DIC_OFS_STATUS)
                         ? (wdata & bmask) : 32'h0000_0000)) | hw_set;
            irq_ff <= |(status_ff & mask_ff);
            arready_ff <= !arready_ff && !rvalid_ff && arvalid;
            if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= 2'b00;
                if (araddr == `DIC_OFS_CTRL) begin
                    rdata_ff <= {24'h000000, ctrl_ff};
                end else if (araddr == `DIC_OFS_THRESH) begin
                    rdata_ff <= {16'h0000, thresh_ff};
                end else if (araddr == `DIC_OFS_STATUS) begin
                    rdata_ff <= status_ff;
                end else if (araddr == `DIC_OFS_MASK) begin
                    rdata_ff <= mask_ff;
                end else if (araddr == `DIC_OFS_INPUT) begin
                    rdata_ff <= {24'h000000, cond_out_ff};
                end else begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= 2'b10;
                end
            end
        end
    end

endmodule // dic_top

`default_nettype wire

// ==== verification/dic_top_chk.sv ====
// Port checker for the digital input conditioning block.
// Assumes binding to dic_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module dic_top_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Field side and store
    input wire logic [7:0]  field_in,
    input wire logic [7:0]  cond_out_ff,
    input wire logic        nv_wr_en_ff,
    // Register bus
    input wire logic        awvalid,
    input wire logic        wvalid,
    input wire logic        awready_ff,
    input wire logic        wready_ff,
    input wire logic        bvalid_ff,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready_ff,
    input wire logic        rvalid_ff,
    input wire logic        rready,
    input wire logic [31:0] rdata_ff,
    input wire logic [1:0]  rresp_ff
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------
    // Bus handshakes
    // ------
    ready_pair_a: assert property (awready_ff == wready_ff)
        else $error("write readies differ");
    write_answer_a: assert property (awvalid && awready_ff && wvalid && wready_ff |=> bvalid_ff)
        else $error("no write response after take");
    bvalid_hold_a: assert property (bvalid_ff && !bready |=> bvalid_ff)
        else $error("write response dropped early");
    read_answer_a: assert property (arvalid && arready_ff |=> rvalid_ff)
        else $error("no read data after take");
    rdata_hold_a: assert property (rvalid_ff && !rready |=> rvalid_ff && $stable(rdata_ff))
        else $error("read data not held");
    rresp_code_a: assert property (rvalid_ff |-> rresp_ff == 2'b00 || rresp_ff == 2'b10)
        else $error("bad read response code");

    // ------
    // Field side and store
    // ------
    nv_pulse_a: assert property (nv_wr_en_ff |=> !nv_wr_en_ff)
        else $error("store write longer than one cycle");
    restore_first_a: assert property ($rose(aresetn) |-> !nv_wr_en_ff [*8])
        else $error("store written during restore");
    rise_cause_a: assert property ($rose(cond_out_ff[0]) |-> $past(field_in[0]))
        else $error("output rose without input");
    fall_cause_a: assert property ($fell(cond_out_ff[0]) |-> !$past(field_in[0], 2))
        else $error("output fell while input high");
endmodule // dic_top_chk

`default_nettype wire

// ==== verification/dic_store_model.sv ====
// Nonvolatile count store that sits beside the field inputs.
// Assumes asynchronous read and one write per enabled clock edge.
`timescale 1ns/10ps
`default_nettype none

module dic_store_model (
    // Clock
    input wire logic         aclk,
    // Store port
    input wire logic         wr_en,
    input wire logic [2:0]   addr,
    input wire logic [31:0]  wdata,
    output logic [31:0]      rdata
);
    logic [31:0] mem [0:7];

    initial begin
        for (int i = 0; i < 8; i++) begin
            mem[i] = 32'h0;
        end
    end

    // Contents survive reset, so the block resumes from the last save.
    assign rdata = mem[addr];

    always @(posedge aclk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
    end
endmodule // dic_store_model

`default_nettype wire

// ==== verification/dic_tb_top.sv ====
// Testbench for the digital input conditioning block.
// Assumes shortened tick (4 cycles) and save period (50 ticks).
`timescale 1ns/10ps
`default_nettype none

module dic_tb_top;
    localparam int TK = 4;
    logic        aclk, aresetn, overcurrent_in, inrush_in, nv_wr_en_ff, irq_ff;
    logic [7:0]  field_in, wire_open_in, awaddr, araddr, cond_out_ff;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [31:0] wdata, rdata_ff, nv_wdata_ff, nv_rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp_ff, rresp_ff, rr, br;
    logic [2:0]  nv_addr_ff;
    int          fails, tests_run, cyc;

    dic_top #(.HAS_OPEN_SENSE(1), .TICK_CYC(32'd4), .SAVE_TK(32'd50)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .field_in(field_in), .wire_open_in(wire_open_in),
        .overcurrent_in(overcurrent_in), .inrush_in(inrush_in), .nv_wr_en_ff(nv_wr_en_ff),
        .nv_addr_ff(nv_addr_ff), .nv_wdata_ff(nv_wdata_ff), .nv_rdata(nv_rdata),
        .cond_out_ff(cond_out_ff), .irq_ff(irq_ff), .awaddr(awaddr), .awvalid(awvalid),
        .awready_ff(awready_ff), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready_ff(wready_ff), .bresp_ff(bresp_ff), .bvalid_ff(bvalid_ff), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready_ff(arready_ff), .rdata_ff(rdata_ff),
        .rresp_ff(rresp_ff), .rvalid_ff(rvalid_ff), .rready(rready));

    dic_store_model store_u (.aclk(aclk), .wr_en(nv_wr_en_ff), .addr(nv_addr_ff),
        .wdata(nv_wdata_ff), .rdata(nv_rdata));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ------
    // Shared tasks
    // ------
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask

    // Each bus task starts on a fresh edge so no handshake signal is driven twice at once.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready_ff) awvalid <= 1'b0;
            if (wready_ff) wvalid <= 1'b0;
        end while (bvalid_ff !== 1'b1);
        br = bresp_ff;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready_ff) arvalid <= 1'b0;
        end while (rvalid_ff !== 1'b1);
        rd = rdata_ff;
        rr = rresp_ff;
        rready <= 1'b0;
    endtask

    task automatic pulse(input int ch);
        field_in <= 8'h01 << ch;
        repeat (20) @(posedge aclk);
        field_in <= 8'h00;
        repeat (80) @(posedge aclk);
    endtask

    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        rdr(8'h00);
        chk("ctrl reset", 32'h00000050, rd);
        rdr(8'h04);
        chk("thresh reset", 32'h00000001, rd);
        wr(8'h04, 32'h00000000);
        wr(8'h04, 32'h0000FDE9);
        chk("refused wresp", 32'h0, {30'h0, br});
        wr(8'h14, 32'h00000000);
        chk("unmapped wresp", 32'h2, {30'h0, br});
        rdr(8'h04);
        chk("thresh refused", 32'h00000001, rd);
        wr(8'h04, 32'h0000FDE8);
        rdr(8'h04);
        chk("thresh max", 32'h0000FDE8, rd);
        wr(8'h04, 32'h00000001);
        rdr(8'h14);
        chk("unmapped resp", 32'h00000002, {30'h0, rr});
        chk("unmapped data", 32'h00000000, rd);
        $display("Test regs done");
    endtask

    task automatic t_filter;
        int f[4] = '{1, 10, 100, 200};
        int s[4] = '{10, 150, 1000, 2000};
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'(i * 80));
            if (i > 0) begin
                field_in <= 8'hFF;
                repeat (f[i] / 2 * TK) @(posedge aclk);
                field_in <= 8'h00;
                repeat ((f[i] + 4) * TK) @(posedge aclk);
                chk("short pulse", 32'h0, {24'h0, cond_out_ff});
            end
            field_in <= 8'hFF;
            repeat ((f[i] + 3) * TK) @(posedge aclk);
            chk("long pulse", 32'hFF, {24'h0, cond_out_ff});
            rdr(8'h10);
            chk("input reg", 32'hFF, rd);
            field_in <= 8'h00;
            repeat ((s[i] - 2) * TK) @(posedge aclk);
            chk("stretch hold", 32'hFF, {24'h0, cond_out_ff});
            repeat ((f[i] + 6) * TK) @(posedge aclk);
            chk("stretch end", 32'h0, {24'h0, cond_out_ff});
        end
        $display("Test filter done");
    endtask

    task automatic t_count;
        wr(8'h00, 32'h00000000);
        pulse(3);
        wr(8'h00, 32'h00000004);
        rdr(8'h08);
        chk("count at limit", 32'h0, {24'h0, rd[23:16]});
        pulse(2);
        pulse(1);
        pulse(1);
        rdr(8'h08);
        chk("count over limit", 32'h04, {24'h0, rd[23:16]});
        repeat (300) @(posedge aclk);
        chk("saved ch1", 32'd2, store_u.mem[1]);
        chk("saved ch2", 32'd1001, store_u.mem[2]);
        chk("saved ch3", 32'd0, store_u.mem[3]);
        // Count once right after a save, then lose power before the next one.
        do @(posedge aclk); while (!(nv_wr_en_ff && nv_addr_ff == 3'h7));
        field_in <= 8'h02;
        repeat (30) @(posedge aclk);
        {aresetn, field_in} <= 9'h000;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (300) @(posedge aclk);
        chk("resumed ch1", 32'd2, store_u.mem[1]);
        $display("Test count done");
    endtask

    task automatic t_open;
        wr(8'h00, 32'h00000050);
        wire_open_in <= 8'h08;
        repeat (10) @(posedge aclk);
        rdr(8'h08);
        chk("open off", 32'h0, {24'h0, rd[15:8]});
        wr(8'h00, 32'h00000052);
        repeat (10) @(posedge aclk);
        rdr(8'h08);
        chk("open on", 32'h08, {24'h0, rd[15:8]});
        wr(8'h0C, 32'h00000800);
        repeat (3) @(posedge aclk);
        chk("irq set", 32'h1, {31'h0, irq_ff});
        wr(8'h0C, 32'h00000000);
        repeat (3) @(posedge aclk);
        chk("irq masked", 32'h0, {31'h0, irq_ff});
        wire_open_in <= 8'h00;
        wr(8'h08, 32'h0000FF00);
        rdr(8'h08);
        chk("open cleared", 32'h0, {24'h0, rd[15:8]});
        $display("Test open done");
    endtask

    task automatic t_inrush;
        wr(8'h00, 32'h00000050);
        overcurrent_in <= 1'b1;
        repeat (2) @(posedge aclk);
        overcurrent_in <= 1'b0;
        rdr(8'h08);
        chk("ovc default", 32'h1, {31'h0, rd[0]});
        wr(8'h08, 32'h00000001);
        wr(8'h00, 32'h00000051);
        inrush_in <= 1'b1;
        @(posedge aclk);
        inrush_in <= 1'b0;
        repeat (3700) @(posedge aclk);
        overcurrent_in <= 1'b1;
        repeat (2) @(posedge aclk);
        overcurrent_in <= 1'b0;
        rdr(8'h08);
        chk("ovc masked", 32'h0, {31'h0, rd[0]});
        repeat (400) @(posedge aclk);
        overcurrent_in <= 1'b1;
        repeat (2) @(posedge aclk);
        overcurrent_in <= 1'b0;
        rdr(8'h08);
        chk("ovc after mask", 32'h1, {31'h0, rd[0]});
        $display("Test inrush done");
    endtask

    initial begin
        {aresetn, overcurrent_in, inrush_in, awvalid, wvalid, bready} = 6'h00;
        {arvalid, rready, field_in, wire_open_in} = 18'h00000;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        fails = 0;
        tests_run = 0;
        cyc = 0;
        wstrb = 4'hF;
        @(posedge aclk);
        store_u.mem[2] = 32'd1000;
        repeat (9) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_filter();
        t_count();
        t_open();
        t_inrush();
        test_done();
    end
endmodule // dic_tb_top

bind dic_top dic_top_chk chk_u (.aclk(aclk), .aresetn(aresetn), .field_in(field_in),
    .cond_out_ff(cond_out_ff), .nv_wr_en_ff(nv_wr_en_ff), .awvalid(awvalid),
    .wvalid(wvalid), .awready_ff(awready_ff), .wready_ff(wready_ff), .bvalid_ff(bvalid_ff),
    .bready(bready), .arvalid(arvalid), .arready_ff(arready_ff), .rvalid_ff(rvalid_ff),
    .rready(rready), .rdata_ff(rdata_ff), .rresp_ff(rresp_ff));

`default_nettype wire
